// *** ndfm_defs.svh ***
`ifndef NDFM_DEFS_SVH
`define NDFM_DEFS_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define NDFM_IDX_DROPNUM  7'h0C
`define NDFM_IDX_STAT0    7'h0E
`define NDFM_IDX_DEPTH    7'h14
`define NDFM_IDX_ISTAT    7'h28
`define NDFM_IDX_IMASK    7'h29
`define NDFM_IDX_CSR      7'h2A
`define NDFM_IDX_DATA0    7'h40

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define NDFM_NSTAT        6
`define NDFM_MAX_DROP     6'h37
`define NDFM_NDROP        56
`define NDFM_DEPTH_PWRUP  6'h01
`define NDFM_CODE_BADDROP 4'hA
`define NDFM_CODE_LINE    4'hC
`define NDFM_IRQ_LINEFAIL 0
`define NDFM_IRQ_LINEOK   1
`define NDFM_IRQ_BADDROP  2
`define NDFM_IRQ_BUSERR   3
`define NDFM_IRQ_TESTDONE 4
`define NDFM_IRQ_W        5

// ----------------------------------------
// timing
// ----------------------------------------
`define NDFM_CLK_MHZ      20
`define NDFM_LINE_TMO_US  1000
`define NDFM_LINE_TMO_CYC (`NDFM_LINE_TMO_US * `NDFM_CLK_MHZ)

`endif

// *** ndfm_pkg.sv ***
package ndfm_pkg;

	// ----------------------------------------
	// operating state, gray along power-up path
	// ----------------------------------------
	typedef enum logic [1:0] {
		NDFM_PWRUP = 2'h0,
		NDFM_TEST  = 2'h1,
		NDFM_RUN   = 2'h3,
		NDFM_FAIL  = 2'h2
	} ndfm_state_t;

	typedef logic [15:0] ndfm_word_t;

endpackage : ndfm_pkg

// *** ndfm_sync.sv ***
module ndfm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	if (W < 1) begin : g_bad_w
		$error("ndfm_sync: W must be at least 1");
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : ndfm_sync

// *** ndfm_cnt16.sv ***
module ndfm_cnt16 (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// control
	input  wire logic        clr,
	input  wire logic        inc,
	// count
	output logic      [15:0] cnt
);

	// counts to all ones then rolls to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
		end else if (clr) begin
			cnt <= 16'h0000;
		end else if (inc) begin
			cnt <= cnt + 16'h0001; // R16
		end
	end

endmodule : ndfm_cnt16

// *** ndfm_top.sv ***
// Function
// (R01) healthy light comes on only after power-up diagnostics pass
// (R02) healthy off with blank display means local watchdog failure
// (R03) drop number above 55 at power-up shows invalid-drop code
// (R04) master raises line-failure code when no other drop is heard
// (R05) slave without master traffic keeps shared data, never clears it
// (R06) data for a failed drop stays frozen at its prior value
// (R07) line-failure code clears by itself once the line is active
// (R08) drop switches sampled only at power-up or self-test reset
// (R09) sampled drop number readable at register 12 of drop-0 area
// (R10) after self test drop depth is zero, link stays failed
// (R11) processor writes valid depth to register 20, failure then clears
// (R12) each drop number answered by exactly one slave, no overlap
// (R13) master counts timeouts, checksum, overrun, abort for whole network
// (R14) write to a read-only register answers with bus error
// (R15) sampled drop number decides which shared areas are writable
// (R16) statistics counters run to 65535 then wrap to zero
// (R17) during self test every backplane access gets a bus error
// (R18) every fault shown as one display code until cleared
//
// The address map and the APB register port were chosen for this implementation.
`include "ndfm_defs.svh"

module ndfm_top #(
	parameter int LINE_TMO_CYC = `NDFM_LINE_TMO_CYC
) (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pins from outside
	input  wire logic [5:0]  drop_sw,
	input  wire logic        wdog_ok,
	// diagnostics and terminal, same clock
	input  wire logic        selftest_req,
	input  wire logic        diag_done,
	input  wire logic        diag_pass,
	input  wire logic [3:0]  diag_code,
	// network receiver and transmitter, same clock
	input  wire logic        rx_valid,
	input  wire logic [5:0]  rx_drop,
	input  wire logic [15:0] rx_data,
	input  wire logic        err_own,
	input  wire logic        err_tmo,
	input  wire logic        err_crc,
	input  wire logic        err_ovr,
	input  wire logic        err_abt,
	input  wire logic        tx_done,
	input  wire logic [5:0]  tx_idx,
	output logic      [15:0] tx_data,
	output logic             net_enable,
	// indicators
	output logic             ok_led,
	output logic             seg_on,
	output logic      [3:0]  seg_code,
	output logic             irq
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	localparam int TW = $clog2(LINE_TMO_CYC + 1);

	ndfm_pkg::ndfm_state_t    state_r;
	ndfm_pkg::ndfm_state_t    state_nxt;
	ndfm_pkg::ndfm_word_t     mem_r [`NDFM_NDROP];
	logic [15:0]              stat_cnt [`NDFM_NSTAT];
	logic [`NDFM_NSTAT-1:0]   stat_inc;
	logic [6:0]               sync_q;
	logic [5:0]               sw_s;
	logic                     wdog_s;
	logic [5:0]               drop_r;
	logic [5:0]               depth_r;
	logic                     bad_drop_r;
	logic                     diag_fail_r;
	logic [3:0]               diag_code_r;
	logic                     line_fail_r;
	logic                     line_fail_nxt;
	logic [TW-1:0]            tmo_r;
	logic [`NDFM_IRQ_W-1:0]   istat_r;
	logic [`NDFM_IRQ_W-1:0]   imask_r;
	logic [`NDFM_IRQ_W-1:0]   ev_set;
	logic                     is_master;
	logic                     heard;
	logic                     test_clr;
	logic                     acc;
	logic                     wr;
	logic [6:0]               idx;
	logic [6:0]               didx;
	logic                     is_data;
	logic                     own_word;
	logic                     rd_ok;
	logic                     wr_ok;
	logic                     err;
	logic [31:0]              rdata;
	logic [1:0]               settle_r;

	if (LINE_TMO_CYC < 1) begin : g_bad_tmo
		$error("ndfm_top: LINE_TMO_CYC must be at least 1");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	ndfm_sync #(.W(7)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({wdog_ok, drop_sw}),
		.q       (sync_q)
	);
	assign sw_s   = sync_q[5:0];
	assign wdog_s = sync_q[6];

	// ----------------------------------------
	// power-up and self test sequence
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ndfm_pkg::NDFM_PWRUP: if (settle_r[1]) state_nxt = ndfm_pkg::NDFM_TEST;
			ndfm_pkg::NDFM_TEST: begin
				if (diag_done) state_nxt = diag_pass ? ndfm_pkg::NDFM_RUN : ndfm_pkg::NDFM_FAIL;
			end
			ndfm_pkg::NDFM_RUN: begin
				if (selftest_req) state_nxt = ndfm_pkg::NDFM_PWRUP;
			end
			ndfm_pkg::NDFM_FAIL: begin
				if (selftest_req) state_nxt = ndfm_pkg::NDFM_PWRUP;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state_r <= ndfm_pkg::NDFM_PWRUP;
		else          state_r <= state_nxt;
	end

	// holds power-up until the switch synchroniser has filled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) settle_r <= 2'b00;
		else          settle_r <= {settle_r[0], 1'b1};
	end

	// self test restart clears depth and counters
	assign test_clr = (state_r != ndfm_pkg::NDFM_PWRUP) && (state_nxt == ndfm_pkg::NDFM_PWRUP);

	// diagnostics result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_fail_r <= 1'b0;
			diag_code_r <= 4'h0;
		end else if (state_r == ndfm_pkg::NDFM_TEST && diag_done) begin
			diag_fail_r <= !diag_pass;
			diag_code_r <= diag_code;
		end
	end

	// ----------------------------------------
	// drop number and depth
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drop_r     <= 6'h00;
			bad_drop_r <= 1'b0;
		end else if (state_r == ndfm_pkg::NDFM_PWRUP) begin
			drop_r     <= sw_s; // R08
			bad_drop_r <= sw_s > `NDFM_MAX_DROP; // R03
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			depth_r <= `NDFM_DEPTH_PWRUP;
		end else if (test_clr) begin
			depth_r <= 6'h00; // R10
		end else if (wr && wr_ok && idx == `NDFM_IDX_DEPTH) begin
			depth_r <= pwdata[5:0]; // R11
		end
	end

	assign is_master  = drop_r == 6'h00;
	assign net_enable = state_r == ndfm_pkg::NDFM_RUN && !bad_drop_r && depth_r != 6'h00;

	// ----------------------------------------
	// line supervision
	// ----------------------------------------
	// master hears any other drop, slave hears the master
	assign heard = rx_valid && (is_master ? rx_drop != 6'h00 : rx_drop == 6'h00); // R04

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_r <= '0;
		end else if (heard || !net_enable) begin
			tmo_r <= '0;
		end else if (tmo_r != TW'(LINE_TMO_CYC)) begin
			tmo_r <= tmo_r + TW'(1);
		end
	end

	always_comb begin
		line_fail_nxt = line_fail_r;
		if (state_r == ndfm_pkg::NDFM_RUN && depth_r == 6'h00) begin
			line_fail_nxt = 1'b1; // R10
		end else if (net_enable && heard) begin
			line_fail_nxt = 1'b0; // R07 R11
		end else if (tmo_r == TW'(LINE_TMO_CYC)) begin
			line_fail_nxt = 1'b1; // R04
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) line_fail_r <= 1'b0;
		else          line_fail_r <= line_fail_nxt;
	end

	// ----------------------------------------
	// shared data words, one per drop
	// ----------------------------------------
	assign didx     = idx - `NDFM_IDX_DATA0;
	assign is_data  = idx >= `NDFM_IDX_DATA0 && didx < 7'(`NDFM_NDROP);
	assign own_word = {1'b0, didx[5:0]} >= {1'b0, drop_r}
		&& {1'b0, didx[5:0]} < ({1'b0, drop_r} + {1'b0, depth_r}); // R15

	generate
		for (genvar g = 0; g < `NDFM_NDROP; g++) begin : g_mem
			logic own_g;
			assign own_g = 7'(g) >= {1'b0, drop_r} && 7'(g) < ({1'b0, drop_r} + {1'b0, depth_r});
			// only live traffic or a processor write updates a word; a silent line leaves it frozen
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mem_r[g] <= 16'h0000;
				end else if (wr && wr_ok && is_data && didx[5:0] == 6'(g)) begin
					mem_r[g] <= pwdata[15:0];
				end else if (net_enable && rx_valid && rx_drop == 6'(g) && !own_g) begin
					mem_r[g] <= rx_data; // R05 R06
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)                   tx_data <= 16'h0000;
		else if (tx_idx < 6'(`NDFM_NDROP)) tx_data <= mem_r[tx_idx];
		else                            tx_data <= 16'h0000;
	end

	// ----------------------------------------
	// network statistics
	// ----------------------------------------
	assign stat_inc[0] = net_enable && rx_valid;
	assign stat_inc[1] = err_tmo && (is_master || err_own); // R13
	assign stat_inc[2] = err_crc && (is_master || err_own); // R13
	assign stat_inc[3] = err_ovr && (is_master || err_own); // R13
	assign stat_inc[4] = err_abt && (is_master || err_own); // R13
	assign stat_inc[5] = tx_done;

	generate
		for (genvar s = 0; s < `NDFM_NSTAT; s++) begin : g_stat
			ndfm_cnt16 u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.clr     (test_clr),
				.inc     (stat_inc[s]),
				.cnt     (stat_cnt[s])
			);
		end
	endgenerate

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign acc    = psel && penable;
	assign idx    = paddr[8:2];
	assign pready = 1'b1;

	always_comb begin
		rd_ok = 1'b1;
		wr_ok = 1'b0;
		rdata = 32'h0000_0000;
		if (idx == `NDFM_IDX_DROPNUM) begin
			rdata = {26'h0, drop_r}; // R09
		end else if (idx >= `NDFM_IDX_STAT0 && idx < `NDFM_IDX_DEPTH) begin
			rdata = {16'h0, stat_cnt[3'(idx - `NDFM_IDX_STAT0)]};
		end else if (idx == `NDFM_IDX_DEPTH) begin
			rdata = {26'h0, depth_r};
			wr_ok = 1'b1;
		end else if (idx == `NDFM_IDX_ISTAT) begin
			rdata = {27'h0, istat_r};
			wr_ok = 1'b1;
		end else if (idx == `NDFM_IDX_IMASK) begin
			rdata = {27'h0, imask_r};
			wr_ok = 1'b1;
		end else if (idx == `NDFM_IDX_CSR) begin
			rdata = {24'h0, is_master, net_enable, line_fail_r, bad_drop_r,
				diag_fail_r, ok_led, state_r};
		end else if (is_data) begin
			rdata = {16'h0, mem_r[didx[5:0]]};
			wr_ok = own_word && !bad_drop_r; // R15
		end else begin
			rd_ok = 1'b0;
		end
	end

	// R14 R17
	assign err     = state_r != ndfm_pkg::NDFM_RUN && state_r != ndfm_pkg::NDFM_FAIL
		|| (pwrite ? !wr_ok : !rd_ok);
	assign wr      = acc && pwrite && !err;
	assign pslverr = acc && err;
	assign prdata  = (acc && !pwrite && !err) ? rdata : 32'h0000_0000;

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	assign ev_set[`NDFM_IRQ_LINEFAIL] = line_fail_nxt && !line_fail_r;
	assign ev_set[`NDFM_IRQ_LINEOK]   = line_fail_r && !line_fail_nxt;
	assign ev_set[`NDFM_IRQ_BADDROP]  = state_r == ndfm_pkg::NDFM_PWRUP && sw_s > `NDFM_MAX_DROP;
	assign ev_set[`NDFM_IRQ_BUSERR]   = pslverr;
	assign ev_set[`NDFM_IRQ_TESTDONE] = state_r == ndfm_pkg::NDFM_TEST && diag_done;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_r <= '0;
		end else if (wr && idx == `NDFM_IDX_ISTAT) begin
			istat_r <= (istat_r & ~pwdata[`NDFM_IRQ_W-1:0]) | ev_set;
		end else begin
			istat_r <= istat_r | ev_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)                             imask_r <= '0;
		else if (wr && idx == `NDFM_IDX_IMASK) imask_r <= pwdata[`NDFM_IRQ_W-1:0];
	end

	assign irq = |(istat_r & imask_r);

	// ----------------------------------------
	// indicators
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ok_led   <= 1'b0;
			seg_on   <= 1'b0;
			seg_code <= 4'h0;
		end else begin
			ok_led <= state_nxt == ndfm_pkg::NDFM_RUN && wdog_s; // R01
			if (!wdog_s) begin
				seg_on   <= 1'b0; // R02
				seg_code <= 4'h0;
			end else if (diag_fail_r) begin
				seg_on   <= 1'b1; // R18
				seg_code <= diag_code_r;
			end else if (bad_drop_r && state_r != ndfm_pkg::NDFM_PWRUP) begin
				seg_on   <= 1'b1; // R03
				seg_code <= `NDFM_CODE_BADDROP;
			end else if (line_fail_r) begin
				seg_on   <= 1'b1; // R18
				seg_code <= `NDFM_CODE_LINE;
			end else begin
				seg_on   <= 1'b0; // R07
				seg_code <= 4'h0;
			end
		end
	end

endmodule : ndfm_top

// *** ndfm_sva.sv ***
`include "ndfm_defs.svh"

// ------------------------------
// port checker
// ------------------------------
module ndfm_sva #(
	parameter int LINE_TMO_CYC = 20
) (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic        pslverr,
	// pins and events
	input wire logic [5:0]  drop_sw,
	input wire logic        wdog_ok,
	input wire logic        selftest_req,
	input wire logic        diag_done,
	input wire logic        diag_pass,
	input wire logic        rx_valid,
	input wire logic [5:0]  rx_drop,
	input wire logic [5:0]  tx_idx,
	input wire logic [15:0] tx_data,
	// indicators
	input wire logic        net_enable,
	input wire logic        ok_led,
	input wire logic        seg_on,
	input wire logic [3:0]  seg_code
);
	localparam int LIM = LINE_TMO_CYC + 4;
	logic       pass_r;
	logic       test_r;
	logic [5:0] cap_r;
	int         quiet_r;
	logic       heard;
	logic       acc;

	assign acc = psel && penable;
	assign heard = rx_valid && net_enable && ((cap_r == 6'h00) ? rx_drop != 6'h00 : rx_drop == 6'h00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pass_r <= 1'b0;
			test_r <= 1'b1;
		end else begin
			pass_r <= (pass_r && !selftest_req) || (diag_done && diag_pass);
			test_r <= selftest_req || (test_r && !diag_done);
		end
	end

	always_ff @(posedge pclk) begin
		if (!presetn || selftest_req) begin
			cap_r <= drop_sw;
		end
		if (!presetn || !ok_led || heard) begin
			quiet_r <= 0;
		end else if (quiet_r < LIM) begin
			quiet_r <= quiet_r + 1;
		end
	end

	sequence s_calm;
		!rx_valid && !(acc && pwrite);
	endsequence
	sequence s_wdog_lost;
		(!wdog_ok)[*4];
	endsequence

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ok_after_pass: assert property (ok_led |-> pass_r)
		else $error("healthy light without passed diagnostics");
	a_wdog_blank: assert property (s_wdog_lost |-> !ok_led && !seg_on)
		else $error("watchdog loss not shown as dark light and blank display");
	a_bad_code: assert property (ok_led && cap_r > `NDFM_MAX_DROP && !$past(selftest_req)
		|-> seg_on && seg_code == `NDFM_CODE_BADDROP)
		else $error("invalid drop not shown");
	a_line_code: assert property (quiet_r >= LIM && ok_led && cap_r <= `NDFM_MAX_DROP
		&& !$past(selftest_req) |-> seg_on && seg_code == `NDFM_CODE_LINE)
		else $error("silent line not shown as line failure");
	a_line_clears: assert property (heard && ok_led
		|-> ##[1:3] !(seg_on && seg_code == `NDFM_CODE_LINE))
		else $error("line failure code stays after traffic");
	a_data_held: assert property (s_calm[*2] ##0 $stable(tx_idx) |=> $stable(tx_data))
		else $error("shared data changed without a write");
	a_ro_write_err: assert property (acc && pwrite && (paddr[8:2] == `NDFM_IDX_DROPNUM
		|| paddr[8:2] == `NDFM_IDX_CSR) |-> pslverr)
		else $error("read only write accepted");
	a_test_buserr: assert property (acc && test_r |-> pslverr)
		else $error("access during self test accepted");
	a_err_in_access: assert property (pslverr |-> acc)
		else $error("bus error outside access phase");
endmodule : ndfm_sva

bind ndfm_top ndfm_sva #(.LINE_TMO_CYC(LINE_TMO_CYC)) u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
	.drop_sw(drop_sw), .wdog_ok(wdog_ok), .selftest_req(selftest_req), .diag_done(diag_done),
	.diag_pass(diag_pass), .rx_valid(rx_valid), .rx_drop(rx_drop), .tx_idx(tx_idx),
	.tx_data(tx_data), .net_enable(net_enable), .ok_led(ok_led), .seg_on(seg_on),
	.seg_code(seg_code));

// *** ndfm_net_model.sv ***
// ------------------------------
// far drops on the network
// ------------------------------
module ndfm_net_model (
	// clock
	input wire logic   pclk,
	// messages
	output logic        rx_valid,
	output logic [5:0]  rx_drop,
	output logic [15:0] rx_data,
	// events
	output logic        err_own,
	output logic        err_tmo,
	output logic        err_crc,
	output logic        err_ovr,
	output logic        err_abt,
	output logic        tx_done,
	output logic [5:0]  tx_idx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] tick;

	initial begin
		{rx_valid, rx_drop, rx_data, err_own, tx_done, tx_idx, tick} = '0;
		{err_tmo, err_crc, err_ovr, err_abt} = 4'h0;
	end

	// transmit side pulls one word every four cycles
	always @(posedge pclk) begin
		tick <= tick + 2'h1;
		tx_done <= (tick == 2'h3);
		if (tick == 2'h3) begin
			tx_idx <= tx_idx + 6'h01;
		end
	end

	// one message, lines show inverse when idle
	task automatic send(input logic [5:0] d, input logic [15:0] v);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_drop <= d;
		rx_data <= v;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_drop <= ~d;
		rx_data <= ~v;
	endtask : send

	task automatic errs(input logic own);
		@(posedge pclk);
		err_own <= own;
		{err_tmo, err_crc, err_ovr, err_abt} <= 4'hF;
		@(posedge pclk);
		{err_tmo, err_crc, err_ovr, err_abt} <= 4'h0;
	endtask : errs
endmodule : ndfm_net_model

// *** testbench.sv ***
`include "ndfm_defs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
	logic [31:0] paddr, pwdata, prdata, rdat;
	logic        wdog_ok, selftest_req, diag_done, diag_pass, rx_valid, tx_done;
	logic        err_own, err_tmo, err_crc, err_ovr, err_abt;
	logic        net_enable, ok_led, seg_on, irq;
	logic [5:0]  drop_sw, rx_drop, tx_idx;
	logic [15:0] rx_data, tx_data;
	logic [3:0]  diag_code, seg_code;
	int          mismatches, check_count, cycles;

	ndfm_top #(.LINE_TMO_CYC(20)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .drop_sw, .wdog_ok, .selftest_req, .diag_done,
		.diag_pass, .diag_code, .rx_valid, .rx_drop, .rx_data, .err_own, .err_tmo, .err_crc,
		.err_ovr, .err_abt, .tx_done, .tx_idx, .tx_data, .net_enable, .ok_led, .seg_on,
		.seg_code, .irq);
	ndfm_net_model u_net (.pclk, .rx_valid, .rx_drop, .rx_data, .err_own, .err_tmo,
		.err_crc, .err_ovr, .err_abt, .tx_done, .tx_idx);

	// ------------------------------
	// clock, timeout, verdict
	// ------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic report_and_stop;
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// ------------------------------
	// access tasks
	// ------------------------------
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [6:0] ix, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {23'h0, ix, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [6:0] ix, input logic [31:0] e);
		apb(1'b0, ix, 32'h0);
		chk("read data", e, rdat);
	endtask : rd

	task automatic acc(input logic w, input logic [6:0] ix, input logic [31:0] wd, input logic e);
		apb(w, ix, wd);
		chk("bus error", 32'(e), 32'(serr));
	endtask : acc

	task automatic diag;
		@(posedge pclk);
		diag_done <= 1'b1;
		@(posedge pclk);
		diag_done <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : diag

	task automatic selftest(input logic [5:0] sw);
		drop_sw <= sw;
		repeat (4) @(posedge pclk);
		selftest_req <= 1'b1;
		@(posedge pclk);
		selftest_req <= 1'b0;
		repeat (3) @(posedge pclk);
		diag();
	endtask : selftest

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, selftest_req, diag_done} = '0;
		{mismatches, check_count, cycles} = '0;
		drop_sw = 6'h03;
		wdog_ok = 1'b1;
		diag_pass = 1'b1;
		diag_code = 4'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, `NDFM_IDX_CSR, 32'h0, 1'b1);
		diag();
		rd(`NDFM_IDX_CSR, 32'h47);
		rd(`NDFM_IDX_DROPNUM, 32'h3);
		acc(1'b1, `NDFM_IDX_DROPNUM, 32'h5, 1'b1);
		acc(1'b1, `NDFM_IDX_CSR, 32'h0, 1'b1);
		acc(1'b0, 7'h30, 32'h0, 1'b1);
		acc(1'b1, `NDFM_IDX_IMASK, 32'h1, 1'b0);
		u_net.send(6'h00, 16'h1234);
		rd(`NDFM_IDX_DATA0, 32'h1234);
		rd(`NDFM_IDX_STAT0, 32'h1);
		acc(1'b1, `NDFM_IDX_DATA0 + 7'h3, 32'hBEEF, 1'b0);
		acc(1'b1, `NDFM_IDX_DATA0 + 7'h4, 32'h1, 1'b1);
		u_net.send(6'h03, 16'h5555);
		rd(`NDFM_IDX_DATA0 + 7'h3, 32'hBEEF);
		u_net.errs(1'b0);
		rd(`NDFM_IDX_STAT0 + 7'h1, 32'h0);
		u_net.errs(1'b1);
		for (int i = 1; i < 5; i++) rd(`NDFM_IDX_STAT0 + 7'(i), 32'h1);
		repeat (30) @(posedge pclk);
		chk("display code", 32'hC, 32'(seg_code));
		chk("irq", 32'h1, 32'(irq));
		rd(`NDFM_IDX_DATA0, 32'h1234);
		u_net.send(6'h00, 16'h0001);
		repeat (3) @(posedge pclk);
		chk("display on", 32'h0, 32'(seg_on));
		acc(1'b1, `NDFM_IDX_ISTAT, 32'h1, 1'b0);
		@(posedge pclk);
		chk("irq", 32'h0, 32'(irq));
		drop_sw <= 6'h00;
		repeat (5) @(posedge pclk);
		rd(`NDFM_IDX_DROPNUM, 32'h3);
		selftest(6'h00);
		rd(`NDFM_IDX_DROPNUM, 32'h0);
		rd(`NDFM_IDX_DEPTH, 32'h0);
		chk("display code", 32'hC, 32'(seg_code));
		acc(1'b1, `NDFM_IDX_DEPTH, 32'h1, 1'b0);
		@(posedge pclk);
		chk("net enable", 32'h1, 32'(net_enable));
		acc(1'b1, `NDFM_IDX_DATA0 + 7'h3, 32'h1, 1'b1);
		u_net.send(6'h05, 16'h00AA);
		repeat (3) @(posedge pclk);
		chk("display on", 32'h0, 32'(seg_on));
		u_net.errs(1'b0);
		for (int i = 1; i < 5; i++) rd(`NDFM_IDX_STAT0 + 7'(i), 32'h1);
		selftest(6'h38);
		chk("display code", 32'hA, 32'(seg_code));
		acc(1'b1, `NDFM_IDX_DATA0, 32'h1, 1'b1);
		diag_pass <= 1'b0;
		diag_code <= 4'h6;
		selftest(6'h38);
		chk("display code", 32'h6, 32'(seg_code));
		chk("healthy light", 32'h0, 32'(ok_led));
		wdog_ok <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("healthy light", 32'h0, 32'(ok_led));
		chk("display on", 32'h0, 32'(seg_on));
		report_and_stop();
	end
endmodule : testbench
